/* rtl/mpt_pkg.sv */
package mpt_pkg;

    // ****************************************************************
    // interface modes and speeds
    // ****************************************************************
    typedef enum logic [1:0] {MPT_GMII, MPT_RGMII, MPT_MII, MPT_REVERSE_MEDIA_INDEPENDENT_MODE} mpt_mode_t;
    typedef enum logic [1:0] {MPT_S10, MPT_S100, MPT_S1000} mpt_speed_t;

    // static port setup, changed only while the port is idle
    typedef struct packed {
        mpt_mode_t mode;
        mpt_speed_t speed;
        logic half_dx;
    } mpt_cfg_t;

    // one byte of a frame from the switch core
    typedef struct packed {
        logic [7:0] data;
        logic err; // corrupt this byte
        logic ext; // carrier extension beat, not frame data
    } mpt_beat_t;

    // ****************************************************************
    // timing: link clock and generated interface clock rates in kHz
    // ****************************************************************
    localparam int LINK_CLK_KHZ = 250000;
    localparam int RATE_1000_KHZ = 125000;
    localparam int RATE_100_KHZ = 25000;
    localparam int RATE_10_KHZ = 2500;
    localparam int HALF_W = 6;
    localparam logic [HALF_W-1:0] HALF_1000 = HALF_W'(LINK_CLK_KHZ / (2 * RATE_1000_KHZ));
    localparam logic [HALF_W-1:0] HALF_100 = HALF_W'(LINK_CLK_KHZ / (2 * RATE_100_KHZ));
    localparam logic [HALF_W-1:0] HALF_10 = HALF_W'(LINK_CLK_KHZ / (2 * RATE_10_KHZ));

    // ****************************************************************
    // pin values and buffer geometry
    // ****************************************************************
    localparam logic [3:0] NIB_IDLE = 4'h0;
    localparam logic [7:0] BYTE_IDLE = 8'h00;
    localparam logic [7:0] BYTE_CEXT = 8'h0f;
    localparam int PTR_W = 2; // two entries plus wrap bit

endpackage

/* rtl/mpt_mgmt_tx.sv */
//
// Overview of operation
// - hardware reset pin, active low, resets all logic
// - source select high means oscillator, low means crystal
// - reverse mode drives the transmit clock pin out at 25 or 2.5 MHz
// - transmit clock pin unused outside MII, slow GMII and reverse mode
// - GMII sends low and high nibble together, one byte per rise
// - RGMII gigabit sends bits 3:0 on rise, bits 7:4 on fall
// - RGMII 10/100 sends one nibble per rising edge on low lines
// - reverse mode drives nibbles on rise of its own output clock
// - MII launches nibbles on rise of the partner's clock
// - GMII/MII enable is high exactly while data pins carry frame data
// - RGMII control: enable at rise, enable xor error at fall
// - reverse mode enable serves as receive data valid for the frame
// - GMII/MII error is raised with enable high, or with enable low for a carrier extension beat
// - carrier extension uses the error output in either duplex, the control line at the fall in RGMII
// - gigabit clock output for RGMII and GMII 1000, edges align data
//
`timescale 1ns/1ps

module mpt_mgmt_tx (
    input wire logic clock, // system clock, 10 MHz
    input wire logic sys_rst, // synchronous reset, active high
    input wire logic clk_en, // freezes all state but the synchronisers while low
    input wire logic hw_reset_n, // hardware reset pin, active low
    input wire logic ref_clock_source_select, // reference source strap pin
    output logic ref_osc_selected, // oscillator in use
    output logic ref_crystal_enable, // crystal amplifier on
    input wire mpt_pkg::mpt_cfg_t cfg, // port mode, speed, duplex
    input wire logic s_valid, // byte offered
    output logic s_ready, // buffer can take a byte
    input wire mpt_pkg::mpt_beat_t s_beat, // offered byte
    input wire logic link_clk, // link timing clock, twice gigabit rate
    input wire logic mgmt_port_mii_tx_clock_in, // partner transmit clock
    output logic mgmt_port_mii_tx_clock_out, // driven clock, reverse mode
    output logic mgmt_port_mii_tx_clock_oe, // clock pin drive enable
    output logic mgmt_port_gigabit_tx_clock, // gigabit transmit clock
    output logic [3:0] mgmt_port_tx_data_low, // data bits 3:0
    output logic [3:0] mgmt_port_tx_data_high, // data bits 7:4
    output logic mgmt_port_tx_enable, // enable or control line
    output logic mgmt_port_tx_error // transmit error
);

    // ****************************************************************
    // system domain: reset pin, strap and source select
    // ****************************************************************
    logic hw_s1_r, hw_s2_r, sel_s1_r, sel_s2_r;
    logic rst_all, rst_all_r;
    logic osc_r, osc_nxt, xtal_r, xtal_nxt;

    // pins pass two flops before anything reads them
    always_ff @(posedge clock)
    begin
        hw_s1_r <= hw_reset_n;
        hw_s2_r <= hw_s1_r;
        sel_s1_r <= ref_clock_source_select;
        sel_s2_r <= sel_s1_r;
    end
    assign rst_all = sys_rst | ~hw_s2_r;

    // high picks the oscillator, low runs the crystal amplifier
    always_comb
    begin
        osc_nxt = osc_r;
        xtal_nxt = xtal_r;
        if (clk_en)
        begin
            osc_nxt = sel_s2_r;
            xtal_nxt = ~sel_s2_r;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst_all)
        begin
            rst_all_r <= 1'b1;
            osc_r <= 1'b0;
            xtal_r <= 1'b1;
        end
        else
        begin
            rst_all_r <= 1'b0;
            osc_r <= osc_nxt;
            xtal_r <= xtal_nxt;
        end
    end

    // ****************************************************************
    // two-entry crossing buffer, write side
    // ****************************************************************
    mpt_pkg::mpt_beat_t mem [2];
    logic [mpt_pkg::PTR_W-1:0] wbin_r, wbin_nxt, wgray_r, wgray_nxt;
    logic [mpt_pkg::PTR_W-1:0] rg_s1_r, rg_s2_r, rgray_r;
    logic rdy_r, rdy_nxt, push;

    // ready is registered, so it is judged on the pointer after this push;
    // a late read pointer only makes it cautious, never overfills
    always_comb
    begin
        push = s_valid & rdy_r & clk_en;
        wbin_nxt = wbin_r;
        if (push)
        begin
            wbin_nxt = wbin_r + 2'h1;
        end
        wgray_nxt = wbin_nxt ^ (wbin_nxt >> 1);
        rdy_nxt = rdy_r;
        if (clk_en)
        begin
            rdy_nxt = (wgray_nxt != ~rg_s2_r);
        end
    end

    always_ff @(posedge clock)
    begin
        rg_s1_r <= rgray_r;
        rg_s2_r <= rg_s1_r;
        if (push)
        begin
            mem[wbin_r[0]] <= s_beat;
        end
        if (rst_all)
        begin
            wbin_r <= '0;
            wgray_r <= '0;
            rdy_r <= 1'b0;
        end
        else
        begin
            wbin_r <= wbin_nxt;
            wgray_r <= wgray_nxt;
            rdy_r <= rdy_nxt;
        end
    end

    // ****************************************************************
    // link domain: synchronisers
    // ****************************************************************
    logic lr_s1_r, lk_rst, ce_s1_r, lk_ce;
    mpt_pkg::mpt_cfg_t cfg_s1_r, lcfg;
    logic [mpt_pkg::PTR_W-1:0] wg_s1_r, wg_s2_r;
    logic mck_s1_r, mck_s2_r, mck_s3_r;

    // setup is quasi-static, so a plain two-flop pass is enough for it
    always_ff @(posedge link_clk)
    begin
        lr_s1_r <= rst_all_r;
        lk_rst <= lr_s1_r;
        ce_s1_r <= clk_en;
        lk_ce <= ce_s1_r;
        cfg_s1_r <= cfg;
        lcfg <= cfg_s1_r;
        wg_s1_r <= wgray_r;
        wg_s2_r <= wg_s1_r;
        mck_s1_r <= mgmt_port_mii_tx_clock_in;
        mck_s2_r <= mck_s1_r;
        mck_s3_r <= mck_s2_r;
    end

    // ****************************************************************
    // link domain: clock generation and transmit pins
    // ****************************************************************
    logic is_rg, is_rv, is_gm, gig, int_gen, gtx_used, byte_mode;
    logic empty, half_end, rise_ev, fall_ev;
    logic [mpt_pkg::HALF_W-1:0] half_lim, half_r, half_nxt;
    logic phase_r, phase_nxt, nib_r, nib_nxt;
    logic [mpt_pkg::PTR_W-1:0] rbin_r, rbin_nxt, rgray_nxt;
    logic [3:0] lo_r, lo_nxt, hi_r, hi_nxt, hih_r, hih_nxt;
    logic en_r, en_nxt, err_r, err_nxt, enh_r, enh_nxt, errh_r, errh_nxt;
    logic gtx_r, gtx_nxt, mco_r, mco_nxt, mcoe_r, mcoe_nxt;
    mpt_pkg::mpt_beat_t rd_beat;

    // mode decode and edge events; rise and fall never coincide
    always_comb
    begin
        is_rg = (lcfg.mode == mpt_pkg::MPT_RGMII);
        is_rv = (lcfg.mode == mpt_pkg::MPT_REVERSE_MEDIA_INDEPENDENT_MODE);
        is_gm = (lcfg.mode == mpt_pkg::MPT_GMII);
        gig = (lcfg.speed == mpt_pkg::MPT_S1000);
        gtx_used = is_rg | (is_gm & gig);
        int_gen = gtx_used | is_rv;
        byte_mode = is_gm | (is_rg & gig);
        unique case (lcfg.speed)
            mpt_pkg::MPT_S1000: half_lim = mpt_pkg::HALF_1000;
            mpt_pkg::MPT_S100: half_lim = mpt_pkg::HALF_100;
            default: half_lim = mpt_pkg::HALF_10;
        endcase
        half_end = (half_r >= half_lim - 6'h01);
        empty = (rgray_r == wg_s2_r);
        rd_beat = mem[rbin_r[0]];
        if (int_gen)
        begin
            rise_ev = lk_ce & half_end & ~phase_r;
            fall_ev = lk_ce & half_end & phase_r & is_rg;
        end
        else
        begin
            rise_ev = lk_ce & mck_s2_r & ~mck_s3_r;
            fall_ev = 1'b0;
        end
    end

    // pins are loaded at the edge where the output clock rises or falls,
    // so clock and data leave together from the same flops
    always_comb
    begin
        half_nxt = half_r;
        phase_nxt = phase_r;
        rbin_nxt = rbin_r;
        nib_nxt = nib_r;
        lo_nxt = lo_r;
        hi_nxt = hi_r;
        hih_nxt = hih_r;
        en_nxt = en_r;
        err_nxt = err_r;
        enh_nxt = enh_r;
        errh_nxt = errh_r;
        gtx_nxt = gtx_r;
        mco_nxt = mco_r;
        mcoe_nxt = mcoe_r;
        if (lk_ce)
        begin
            if (!int_gen)
            begin
                half_nxt = '0;
                phase_nxt = 1'b0;
            end
            else if (half_end)
            begin
                half_nxt = '0;
                phase_nxt = ~phase_r;
            end
            else
            begin
                half_nxt = half_r + 6'h01;
            end
            gtx_nxt = phase_nxt & gtx_used;
            mco_nxt = phase_nxt & is_rv;
            mcoe_nxt = is_rv;
        end
        if (rise_ev && !empty)
        begin
            enh_nxt = ~rd_beat.ext;
            errh_nxt = rd_beat.err | rd_beat.ext;
            hih_nxt = rd_beat.data[7:4];
            en_nxt = ~rd_beat.ext;
            err_nxt = is_rg ? 1'b0 : (rd_beat.err | rd_beat.ext);
            lo_nxt = nib_r ? rd_beat.data[7:4] : rd_beat.data[3:0];
            hi_nxt = is_gm ? rd_beat.data[7:4] : mpt_pkg::NIB_IDLE;
            if (byte_mode || nib_r)
            begin
                rbin_nxt = rbin_r + 2'h1;
            end
            nib_nxt = byte_mode ? 1'b0 : ~nib_r;
        end
        else if (rise_ev)
        begin
            en_nxt = 1'b0;
            err_nxt = 1'b0;
            enh_nxt = 1'b0;
            errh_nxt = 1'b0;
            lo_nxt = mpt_pkg::BYTE_IDLE[3:0];
            hi_nxt = mpt_pkg::BYTE_IDLE[7:4];
            hih_nxt = mpt_pkg::BYTE_IDLE[7:4];
        end
        else if (fall_ev)
        begin
            lo_nxt = byte_mode ? hih_r : lo_r;
            en_nxt = enh_r ^ errh_r;
        end
        rgray_nxt = rbin_nxt ^ (rbin_nxt >> 1);
    end

    always_ff @(posedge link_clk)
    begin
        if (lk_rst)
        begin
            half_r <= '0;
            phase_r <= 1'b0;
            rbin_r <= '0;
            rgray_r <= '0;
            nib_r <= 1'b0;
            lo_r <= 4'h0;
            hi_r <= 4'h0;
            hih_r <= 4'h0;
            en_r <= 1'b0;
            err_r <= 1'b0;
            enh_r <= 1'b0;
            errh_r <= 1'b0;
            gtx_r <= 1'b0;
            mco_r <= 1'b0;
            mcoe_r <= 1'b0;
        end
        else
        begin
            half_r <= half_nxt;
            phase_r <= phase_nxt;
            rbin_r <= rbin_nxt;
            rgray_r <= rgray_nxt;
            nib_r <= nib_nxt;
            lo_r <= lo_nxt;
            hi_r <= hi_nxt;
            hih_r <= hih_nxt;
            en_r <= en_nxt;
            err_r <= err_nxt;
            enh_r <= enh_nxt;
            errh_r <= errh_nxt;
            gtx_r <= gtx_nxt;
            mco_r <= mco_nxt;
            mcoe_r <= mcoe_nxt;
        end
    end

    // every output leaves straight from a flop
    assign ref_osc_selected = osc_r;
    assign ref_crystal_enable = xtal_r;
    assign s_ready = rdy_r;
    assign mgmt_port_mii_tx_clock_out = mco_r;
    assign mgmt_port_mii_tx_clock_oe = mcoe_r;
    assign mgmt_port_gigabit_tx_clock = gtx_r;
    assign mgmt_port_tx_data_low = lo_r;
    assign mgmt_port_tx_data_high = hi_r;
    assign mgmt_port_tx_enable = en_r;
    assign mgmt_port_tx_error = err_r;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge link_clk);
    endclocking
    default disable iff (lk_rst);
    sequence s_word_rise;
        rise_ev && !empty;
    endsequence

    sequence s_gig_fall;
        ##1 fall_ev && byte_mode;
    endsequence

    a_reset_pin: assert property (@(posedge clock) disable iff (sys_rst)
        !hw_s2_r |=> !rdy_r && !osc_r && xtal_r && rst_all_r)
        else $error("reset pin did not hold ready low");
    a_source_sel: assert property (@(posedge clock) disable iff (rst_all)
        clk_en && sel_s2_r |=> osc_r && !xtal_r)
        else $error("source select not followed");
    a_clk_pin_idle: assert property (!is_rv && lk_ce |=> !mgmt_port_mii_tx_clock_oe)
        else $error("transmit clock pin driven outside reverse mode");
    a_rv_clk_edge: assert property (is_rv && lk_ce && half_end
        |=> mgmt_port_mii_tx_clock_out != $past(mgmt_port_mii_tx_clock_out))
        else $error("reverse mode clock did not toggle");
    a_gmii_byte: assert property (is_gm and s_word_rise
        |=> {hi_r, lo_r} == $past(rd_beat.data))
        else $error("gmii byte not presented whole");
    a_rgmii_high: assert property ((s_word_rise ##0 is_rg && gig) ##0 s_gig_fall
        |=> lo_r == $past(hih_r))
        else $error("rgmii high nibble missing on fall");
    a_rgmii_ctl: assert property (fall_ev |=> en_r == $past(enh_r ^ errh_r))
        else $error("rgmii control wrong at fall");
    a_idle_quiet: assert property (rise_ev && empty
        |=> !en_r && !err_r && lo_r == 4'h0 && hi_r == 4'h0)
        else $error("pins not quiet between frames");
    a_err_with_en: assert property (err_r && !en_r |-> $past(rd_beat.ext)
        || $past(err_r && !en_r))
        else $error("error without enable outside extension");

endmodule

/* tb/mpt_mac_model.sv */
`timescale 1ns/1ps

// ****************************************************************
// far-side management mac: supplies the slow tx clock, captures pins
// ****************************************************************
module mpt_mac_model (
    input wire logic link_clk, // samples the pins in generated-clock modes
    input wire mpt_pkg::mpt_cfg_t cfg, // mode and speed, static while traffic runs
    output logic tx_clock_in, // transmit clock supplied to the port
    input wire logic tx_clock_out, // clock driven by the port in reverse mode
    input wire logic gtx, // gigabit clock from the port
    input wire logic [3:0] d_lo, // data bits 3:0
    input wire logic [3:0] d_hi, // data bits 7:4
    input wire logic en, // enable or control line
    input wire logic er, // error line
    output logic got_tgl, // toggles once for each captured beat
    output mpt_pkg::mpt_beat_t got, // captured beat
    output logic [7:0] period_seen // link cycles between two rises of the port clock
);
    logic use_in, ddr, byte_m, gclk, gclk_q, ph, ctl_q, er_q;
    logic [3:0] lo_q;
    logic [7:0] cnt;

    // mode decode, slow gmii and mii take our clock
    assign use_in = (cfg.mode == mpt_pkg::MPT_MII) ||
        (cfg.mode == mpt_pkg::MPT_GMII && cfg.speed != mpt_pkg::MPT_S1000);
    assign ddr = cfg.mode == mpt_pkg::MPT_RGMII && cfg.speed == mpt_pkg::MPT_S1000;
    assign byte_m = cfg.mode == mpt_pkg::MPT_GMII || ddr;
    assign gclk = (cfg.mode == mpt_pkg::MPT_REVERSE_MEDIA_INDEPENDENT_MODE) ? tx_clock_out : gtx;

    initial
    begin
        {got_tgl, ph, gclk_q, ctl_q, er_q, cnt, period_seen, lo_q} = '0;
        got = '0;
        tx_clock_in = 1'b0;
    end

    task automatic emit(input logic [7:0] d, input logic e, input logic x);
        got = '{data: d, err: e, ext: x};
        got_tgl = ~got_tgl;
    endtask

    // one rising edge: byte modes take a byte, nibble modes pair low then high
    task automatic rise();
        if (!en)
        begin
            ph = 1'b0;
            if (er)
                emit(8'h00, 1'b1, 1'b1);
        end
        else if (byte_m)
            emit({d_hi, d_lo}, er, 1'b0);
        else if (!ph)
        begin
            lo_q = d_lo;
            er_q = er;
            ph = 1'b1;
        end
        else
        begin
            emit({d_lo, lo_q}, er | er_q, 1'b0);
            ph = 1'b0;
        end
    endtask

    // free-running slow clock, 640 ns so the port can resync it; still when unused
    always #320 tx_clock_in = use_in ? ~tx_clock_in : 1'b0;

    // the port relaunches a few link cycles after our rise, so sample at our next rise
    always @(posedge tx_clock_in)
        rise();

    // generated-clock modes: values read here are those launched on the previous edge
    always @(posedge link_clk)
    begin
        cnt = cnt + 8'h01;
        if (!use_in && gclk && !gclk_q)
        begin
            period_seen = cnt;
            cnt = 8'h00;
            if (ddr)
            begin
                lo_q = d_lo;
                ctl_q = en;
            end
            else
            begin
                ctl_q = en;
                rise();
            end
        end
        // slow rgmii carries the error only as a change of control at the fall
        if (cfg.mode == mpt_pkg::MPT_RGMII && !ddr && !gclk && gclk_q && ph)
            er_q = er_q | (en ^ ctl_q);
        if (ddr && !gclk && gclk_q && ctl_q)
            emit({d_lo, lo_q}, en ^ ctl_q, 1'b0);
        gclk_q = gclk;
    end
endmodule

/* tb/mpt_mgmt_tx_tb.sv */
`timescale 1ns/1ps

module mpt_mgmt_tx_tb;
    logic clock = 1'b0;
    logic link_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic hw_reset_n = 1'b1;
    logic osc_sel = 1'b0;
    logic s_valid = 1'b0;
    logic s_ready, osc_on, xtal_on, clk_in, clk_out, clk_oe, gtx, en, er, got_tgl;
    logic [3:0] d_lo, d_hi;
    logic [7:0] period_seen, d_idle;
    mpt_pkg::mpt_cfg_t cfg = '{mode: mpt_pkg::MPT_GMII, speed: mpt_pkg::MPT_S1000, half_dx: 1'b0};
    mpt_pkg::mpt_beat_t s_beat = '0;
    mpt_pkg::mpt_beat_t got, b;
    mpt_pkg::mpt_beat_t exp_q[$];
    mpt_pkg::mpt_mode_t mt[7] = '{mpt_pkg::MPT_GMII, mpt_pkg::MPT_RGMII, mpt_pkg::MPT_RGMII,
        mpt_pkg::MPT_MII, mpt_pkg::MPT_REVERSE_MEDIA_INDEPENDENT_MODE, mpt_pkg::MPT_GMII, mpt_pkg::MPT_GMII};
    mpt_pkg::mpt_speed_t st[7] = '{mpt_pkg::MPT_S1000, mpt_pkg::MPT_S1000, mpt_pkg::MPT_S100,
        mpt_pkg::MPT_S100, mpt_pkg::MPT_S100, mpt_pkg::MPT_S100, mpt_pkg::MPT_S1000};
    int fail_count = 0;
    int n_checks = 0;
    int i, k, w;

    // ****************************************************************
    // clocks, phase offset keeps the link clock unrelated to the system one
    // ****************************************************************
    always #50 clock = ~clock;
    initial
    begin
        #7;
        forever #16 link_clk = ~link_clk;
    end

    mpt_mgmt_tx i_dut (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
        .hw_reset_n(hw_reset_n), .ref_clock_source_select(osc_sel), .ref_osc_selected(osc_on),
        .ref_crystal_enable(xtal_on), .cfg(cfg), .s_valid(s_valid), .s_ready(s_ready),
        .s_beat(s_beat), .link_clk(link_clk), .mgmt_port_mii_tx_clock_in(clk_in),
        .mgmt_port_mii_tx_clock_out(clk_out), .mgmt_port_mii_tx_clock_oe(clk_oe),
        .mgmt_port_gigabit_tx_clock(gtx), .mgmt_port_tx_data_low(d_lo),
        .mgmt_port_tx_data_high(d_hi), .mgmt_port_tx_enable(en), .mgmt_port_tx_error(er));

    mpt_mac_model i_mac (.link_clk(link_clk), .cfg(cfg), .tx_clock_in(clk_in),
        .tx_clock_out(clk_out), .gtx(gtx), .d_lo(d_lo), .d_hi(d_hi), .en(en), .er(er),
        .got_tgl(got_tgl), .got(got), .period_seen(period_seen));

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // a carrier extension beat carries no data, only its kind is compared
    task automatic chk_beat(input mpt_pkg::mpt_beat_t g, input mpt_pkg::mpt_beat_t e);
        n_checks++;
        if ({g.ext, g.err | g.ext, g.ext ? 8'h00 : g.data} !==
            {e.ext, e.err | e.ext, e.ext ? 8'h00 : e.data})
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic timeout();
        fail_count++;
        $display("Error at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
        conclude();
    endtask

    // ****************************************************************
    // scoreboard: every captured beat must be the oldest one pushed
    // ****************************************************************
    // the model's own start-up value of the toggle is not a beat
    always @(got_tgl)
        if (exp_q.size() == 0 && $time > 0)
            chk_beat(got, 'x);
        else if ($time > 0)
            chk_beat(got, exp_q.pop_front());

    // called at a falling edge; valid stays high so back-to-back pushes need no gap
    task automatic push(input mpt_pkg::mpt_beat_t bt);
        int n;
        s_valid = 1'b1;
        s_beat = bt;
        for (n = 0; n < 400 && !(s_ready === 1'b1 && clk_en); n++)
            @(negedge clock);
        if (n == 400)
            timeout();
        @(posedge clock);
        exp_q.push_back(bt);
        @(negedge clock);
    endtask

    // stop offering, wait for the queue to empty, then look at the idle pins
    task automatic drain();
        int n;
        s_valid = 1'b0;
        for (n = 0; n < 4000 && exp_q.size() != 0; n++)
            @(posedge link_clk);
        if (n == 4000)
            timeout();
        repeat (60) @(posedge link_clk);
        #1;
        chk({6'h00, en, er}, 8'h00);
        d_idle = {d_hi, d_lo};
        repeat (20) @(posedge link_clk);
        #1;
        chk({d_hi, d_lo}, d_idle);
    endtask

    initial
    begin
        #2000000;
        timeout();
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        void'($urandom(32'haa53910f));
        repeat (3) @(negedge clock);
        sys_rst = 1'b0;
        for (k = 0; k < 7; k++)
        begin
            cfg = '{mode: mt[k], speed: st[k], half_dx: k == 6};
            repeat (10) @(negedge clock);
            for (i = 0; i < 8; i++)
            begin
                if (k == 2 && i == 4)
                begin
                    // freeze mid-stream, no byte may be lost or repeated
                    clk_en = 1'b0;
                    repeat (5) @(negedge clock);
                    clk_en = 1'b1;
                end
                b.data = 8'($urandom());
                b.err = (i == 3);
                b.ext = (k == 6 && i == 7);
                push(b);
            end
            drain();
            chk({7'h00, clk_oe}, {7'h00, mt[k] == mpt_pkg::MPT_REVERSE_MEDIA_INDEPENDENT_MODE});
            if (mt[k] == mpt_pkg::MPT_MII || (mt[k] == mpt_pkg::MPT_GMII && k == 5))
                chk({6'h00, gtx, clk_out}, 8'h00);
            else if (st[k] == mpt_pkg::MPT_S1000)
                chk(period_seen, 8'(2 * mpt_pkg::HALF_1000));
            else
                chk(period_seen, 8'(2 * mpt_pkg::HALF_100));
        end
        // strap pin selects the reference source; the 25 MHz reference is taken as running
        osc_sel = 1'b1;
        repeat (5) @(negedge clock);
        chk({6'h00, osc_on, xtal_on}, 8'h02);
        osc_sel = 1'b0;
        repeat (5) @(negedge clock);
        chk({6'h00, osc_on, xtal_on}, 8'h01);
        // hardware reset pin while the port runs its gigabit clock
        cfg = '{mode: mpt_pkg::MPT_RGMII, speed: mpt_pkg::MPT_S1000, half_dx: 1'b0};
        repeat (10) @(negedge clock);
        hw_reset_n = 1'b0;
        repeat (5) @(negedge clock);
        chk({5'h00, s_ready, osc_on, xtal_on}, 8'h01);
        chk({5'h00, gtx, en, er}, 8'h00);
        hw_reset_n = 1'b1;
        for (w = 0; w < 20 && s_ready !== 1'b1; w++)
            @(negedge clock);
        chk({7'h00, s_ready}, 8'h01);
        conclude();
    end
endmodule
